// *** iopd_board_model.sv ***
// board model: resolves the level seen at each port pin
// assumes registered pin drive outputs from the port block
module iopd_board_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] pin_out_in,
  input wire logic [7:0] pin_oe_in,
  input wire logic [7:0] pullup_en_in,
  input wire logic [7:0] board_val_in,
  input wire logic [7:0] board_en_in,
  output logic [7:0] pin_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // pin resolution
  // ****************************************************************
  logic [7:0] float_reg = 8'h00;
  // floating pins wander so a stale value is never trusted
  always_ff @(posedge sys_clk_in) begin
    float_reg <= ~float_reg;
  end
  // port driver wins, then board, then weak pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe_in[i]) begin
        pin_level_out[i] = pin_out_in[i];
      end else if (board_en_in[i]) begin
        pin_level_out[i] = board_val_in[i];
      end else if (pullup_en_in[i]) begin
        pin_level_out[i] = 1'b1;
      end else begin
        pin_level_out[i] = float_reg[i];
      end
    end
  end
endmodule

// *** iopd_pin_mux.sv ***
// per-pin output selection: alternate function over latch
// assumes inputs are synchronous to sys_clk_in
module iopd_pin_mux (
  input wire logic [7:0] latch_in,
  input wire logic [7:0] dir_in,
  input wire iopd_pkg::iopd_alt_type alt_in,
  output logic [7:0] drive_val_out,
  output logic [7:0] drive_en_out,
  output logic [7:0] alt_active_out
);

  // ****************************************************************
  // alternate output routing
  // ****************************************************************
  // buzzer beats pwm five on pin 5
  always_comb begin
    alt_active_out = 8'h00;
    drive_val_out = latch_in;
    for (int i = 0; i < iopd_pkg::PWM_CHANNELS; i++) begin
      if (alt_in.pwm_oe[i]) begin
        alt_active_out[i] = 1'b1;
        drive_val_out[i] = alt_in.pwm_out[i];
      end
    end
    if (alt_in.buz_en) begin
      alt_active_out[iopd_pkg::BUZZER_PIN] = 1'b1;
      drive_val_out[iopd_pkg::BUZZER_PIN] = alt_in.buz_out;
    end
    // alternate output forces output mode
    drive_en_out = dir_in | alt_active_out;
  end

endmodule

// *** iopd_pkg.sv ***
// package for the port A direction / alternate-function block
// assumes a byte-wide cpu register port with one-cycle read latency
package iopd_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [3:0] OFF_DATA = 4'h0;
  localparam logic [3:0] OFF_DIR = 4'h1;
  localparam logic [3:0] OFF_DRIVE = 4'h2;
  localparam logic [3:0] OFF_STATUS = 4'h3;

  // ****************************************************************
  // field layout and reset values
  // ****************************************************************
  localparam int DRIVE_PIN4_BIT = 1;
  localparam int DRIVE_PIN5_BIT = 2;
  localparam logic [7:0] DRIVE_WMASK = 8'h06;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int PWM_CHANNELS = 6;
  localparam int BUZZER_PIN = 5;
  localparam int INTA_PIN = 6;
  localparam int INTB_PIN = 7;

  // bus request bundle
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } iopd_bus_type;

  // peripheral alternate outputs
  typedef struct packed {
    logic [5:0] pwm_out;
    logic [5:0] pwm_oe;
    logic buz_out;
    logic buz_en;
  } iopd_alt_type;

endpackage

// *** iopd_port.sv ***
// port A logic: direction, data latch, alternate outputs, drive select
// assumes a synchronous cpu register port and pins already synchronised
//
// Contract
// - direction bit 1 makes pin output, 0 makes it input
// - direction register reads back last value written
// - data write updates latch even for input pins
// - data read: latch for outputs, pin level for inputs
// - bit positions without a pin read zero and act as inputs
// - reset clears direction and data latch, all pins inputs
// - input mode: driver off, read comes from pin input stage
// - output mode: driver on with latch value, read returns latch
// - active peripheral output drives pin, forces output mode
// - peripheral input gets pin level, direction zero, no pull-up; code keeps the pull-up on for every undriven pin
// - alternate-function pin reads pin state like input mode
// - pins 0 to 5 output pwm channel when its enable is 1
// - buzzer wins over pwm five on pin 5
// - weak pull-up in input mode; pins 6,7 feed interrupts
// - drive control bits 7 to 3 read zero
// - drive bit 2 selects pin 5 8 mA when pin outputs
// - drive bit 1 selects pin 4 8 mA when pin outputs
module iopd_port #(
  parameter logic [7:0] PIN_PRESENT = 8'hff
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire iopd_pkg::iopd_bus_type bus_in,
  output logic [7:0] rdata_out,
  input wire iopd_pkg::iopd_alt_type alt_in,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe_out,
  output logic [7:0] pullup_en_out,
  output logic [7:0] periph_in_out,
  output logic external_interrupt_a_out,
  output logic external_interrupt_b_out,
  output logic high_drive_select_pin4_out,
  output logic high_drive_select_pin5_out
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] port_direction_register_reg;
  logic [7:0] port_data_latch_reg;
  logic [7:0] pin_drive_strength_control_reg;
  logic [7:0] drive_val;
  logic [7:0] drive_en;
  logic [7:0] alt_active;
  logic [7:0] read_view;
  logic [7:0] rdata_next;

  // write decode shared by all registers
  function automatic logic wr_hit(input iopd_pkg::iopd_bus_type b,
                                  input logic [3:0] off);
    return b.wr && (b.addr == off);
  endfunction

  // ****************************************************************
  // output selection
  // ****************************************************************
  iopd_pin_mux u_mux (
    .latch_in(port_data_latch_reg),
    .dir_in(port_direction_register_reg),
    .alt_in(alt_in),
    .drive_val_out(drive_val),
    .drive_en_out(drive_en),
    .alt_active_out(alt_active)
  );

  // ****************************************************************
  // registers
  // ****************************************************************
  // direction register, absent pins stay input
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_direction_register_reg <= iopd_pkg::RESET_BYTE;
    end else if (wr_hit(bus_in, iopd_pkg::OFF_DIR)) begin
      port_direction_register_reg <= bus_in.wdata & PIN_PRESENT;
    end
  end

  // data latch written regardless of direction
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_data_latch_reg <= iopd_pkg::RESET_BYTE;
    end else if (wr_hit(bus_in, iopd_pkg::OFF_DATA)) begin
      port_data_latch_reg <= bus_in.wdata;
    end
  end

  // drive control: only bits 2 and 1 are storage
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_drive_strength_control_reg <= iopd_pkg::RESET_BYTE;
    end else if (wr_hit(bus_in, iopd_pkg::OFF_DRIVE)) begin
      pin_drive_strength_control_reg <=
        bus_in.wdata & iopd_pkg::DRIVE_WMASK;
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  // latch for plain outputs, pin otherwise; alternate pins show pin
  always_comb begin
    read_view = ((port_data_latch_reg & port_direction_register_reg &
                  ~alt_active) |
                 (pin_in & ~(port_direction_register_reg & ~alt_active)))
                & PIN_PRESENT;
    rdata_next = 8'h00;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        iopd_pkg::OFF_DATA: rdata_next = read_view;
        iopd_pkg::OFF_DIR: rdata_next = port_direction_register_reg;
        iopd_pkg::OFF_DRIVE: rdata_next = pin_drive_strength_control_reg;
        iopd_pkg::OFF_STATUS: rdata_next = drive_en & PIN_PRESENT;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else begin
      rdata_out <= rdata_next;
    end
  end

  // ****************************************************************
  // pads
  // ****************************************************************
  // registered pad controls; costs one cycle of pwm latency
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_out <= 8'h00;
      pin_oe_out <= 8'h00;
      pullup_en_out <= 8'h00;
    end else begin
      pin_out <= drive_val & drive_en & PIN_PRESENT;
      pin_oe_out <= drive_en & PIN_PRESENT;
      pullup_en_out <= ~drive_en & PIN_PRESENT;
    end
  end

  // peripheral inputs see raw pin level, no pull-up modelled here
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      periph_in_out <= 8'h00;
      external_interrupt_a_out <= 1'b0;
      external_interrupt_b_out <= 1'b0;
    end else begin
      periph_in_out <= pin_in & PIN_PRESENT;
      external_interrupt_a_out <= pin_in[iopd_pkg::INTA_PIN];
      external_interrupt_b_out <= pin_in[iopd_pkg::INTB_PIN];
    end
  end

  // high drive only when the pin actually drives
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      high_drive_select_pin4_out <= 1'b0;
      high_drive_select_pin5_out <= 1'b0;
    end else begin
      high_drive_select_pin4_out <= drive_en[4] &
        pin_drive_strength_control_reg[iopd_pkg::DRIVE_PIN4_BIT];
      high_drive_select_pin5_out <= drive_en[5] &
        pin_drive_strength_control_reg[iopd_pkg::DRIVE_PIN5_BIT];
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_dir_write;
    bus_in.wr && bus_in.addr == iopd_pkg::OFF_DIR;
  endsequence

  property p_dir_readback;
    @(posedge sys_clk_in) disable iff (rst_in)
    (s_dir_write ##1 (bus_in.rd && bus_in.addr == iopd_pkg::OFF_DIR &&
     !bus_in.wr)) |=> rdata_out == ($past(bus_in.wdata, 2) & PIN_PRESENT);
  endproperty
  a_dir_readback: assert property (p_dir_readback)
    else $error("direction readback wrong");

  property p_latch_write;
    @(posedge sys_clk_in) disable iff (rst_in)
    (bus_in.wr && bus_in.addr == iopd_pkg::OFF_DATA) |=>
      port_data_latch_reg == $past(bus_in.wdata);
  endproperty
  a_latch_write: assert property (p_latch_write)
    else $error("latch not updated");

  property p_input_no_drive;
    @(posedge sys_clk_in) disable iff (rst_in)
    (port_direction_register_reg[7] == 1'b0) |=> !pin_oe_out[7];
  endproperty
  a_input_no_drive: assert property (p_input_no_drive)
    else $error("input pin driven");

  property p_output_drive;
    @(posedge sys_clk_in) disable iff (rst_in)
    port_direction_register_reg[6] && PIN_PRESENT[6] |=>
      pin_oe_out[6] && pin_out[6] == $past(port_data_latch_reg[6]);
  endproperty
  a_output_drive: assert property (p_output_drive)
    else $error("output pin not driving latch");

  property p_pwm_route;
    @(posedge sys_clk_in) disable iff (rst_in)
    alt_in.pwm_oe[0] && PIN_PRESENT[0] |=>
      pin_oe_out[0] && pin_out[0] == $past(alt_in.pwm_out[0]);
  endproperty
  a_pwm_route: assert property (p_pwm_route)
    else $error("pwm not routed");

  property p_buzzer_wins;
    @(posedge sys_clk_in) disable iff (rst_in)
    alt_in.buz_en && alt_in.pwm_oe[5] && PIN_PRESENT[5] |=>
      pin_out[5] == $past(alt_in.buz_out);
  endproperty
  a_buzzer_wins: assert property (p_buzzer_wins)
    else $error("buzzer lost to pwm");

  property p_alt_read_pin;
    @(posedge sys_clk_in) disable iff (rst_in)
    (bus_in.rd && bus_in.addr == iopd_pkg::OFF_DATA && alt_active[1]) |=>
      rdata_out[1] == ($past(pin_in[1]) & PIN_PRESENT[1]);
  endproperty
  a_alt_read_pin: assert property (p_alt_read_pin)
    else $error("alternate read not pin");

  property p_reserved_zero;
    @(posedge sys_clk_in) disable iff (rst_in)
    (bus_in.rd && bus_in.addr == iopd_pkg::OFF_DRIVE) |=>
      rdata_out[7:3] == 5'h00 && rdata_out[0] == 1'b0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved drive bits set");

  property p_drive5_gated;
    @(posedge sys_clk_in) disable iff (rst_in)
    !drive_en[5] |=> !high_drive_select_pin5_out;
  endproperty
  a_drive5_gated: assert property (p_drive5_gated)
    else $error("high drive on input pin");

  property p_data_read;
    @(posedge sys_clk_in) disable iff (rst_in)
    (bus_in.rd && bus_in.addr == iopd_pkg::OFF_DATA &&
     !port_direction_register_reg[2] && !alt_active[2]) |=>
      rdata_out[2] == ($past(pin_in[2]) & PIN_PRESENT[2]);
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("input read not pin level");

  // peripheral and interrupt taps copy the pin one cycle later
  property p_periph_raw;
    @(posedge sys_clk_in) disable iff (rst_in)
    1'b1 |=> periph_in_out == ($past(pin_in) & PIN_PRESENT);
  endproperty
  a_periph_raw: assert property (p_periph_raw)
    else $error("peripheral input not pin level");

  property p_int_pins;
    @(posedge sys_clk_in) disable iff (rst_in)
    1'b1 |=>
      external_interrupt_a_out == $past(pin_in[iopd_pkg::INTA_PIN]) &&
      external_interrupt_b_out == $past(pin_in[iopd_pkg::INTB_PIN]);
  endproperty
  a_int_pins: assert property (p_int_pins)
    else $error("interrupt line not pin level");

  property p_pullup_input;
    @(posedge sys_clk_in) disable iff (rst_in)
    !port_direction_register_reg[7] && PIN_PRESENT[7] |=> pullup_en_out[7];
  endproperty
  a_pullup_input: assert property (p_pullup_input)
    else $error("input pin without pull-up");

  property p_drive4_gated;
    @(posedge sys_clk_in) disable iff (rst_in)
    !port_direction_register_reg[4] && !alt_in.pwm_oe[4] |=>
      !high_drive_select_pin4_out;
  endproperty
  a_drive4_gated: assert property (p_drive4_gated)
    else $error("pin 4 high drive while input");

  property p_drive4_sel;
    @(posedge sys_clk_in) disable iff (rst_in)
    port_direction_register_reg[4] || alt_in.pwm_oe[4] |=>
      high_drive_select_pin4_out ==
      $past(pin_drive_strength_control_reg[iopd_pkg::DRIVE_PIN4_BIT]);
  endproperty
  a_drive4_sel: assert property (p_drive4_sel)
    else $error("pin 4 drive select wrong");

  property p_drive5_sel;
    @(posedge sys_clk_in) disable iff (rst_in)
    port_direction_register_reg[5] || alt_in.pwm_oe[5] || alt_in.buz_en |=>
      high_drive_select_pin5_out ==
      $past(pin_drive_strength_control_reg[iopd_pkg::DRIVE_PIN5_BIT]);
  endproperty
  a_drive5_sel: assert property (p_drive5_sel)
    else $error("pin 5 drive select wrong");

  property p_latch_read;
    @(posedge sys_clk_in) disable iff (rst_in)
    (bus_in.rd && bus_in.addr == iopd_pkg::OFF_DATA &&
     port_direction_register_reg[3] && !alt_in.pwm_oe[3]) |=>
      rdata_out[3] == ($past(port_data_latch_reg[3]) & PIN_PRESENT[3]);
  endproperty
  a_latch_read: assert property (p_latch_read)
    else $error("output read not latch");

  property p_drive_mask;
    @(posedge sys_clk_in) disable iff (rst_in)
    (bus_in.wr && bus_in.addr == iopd_pkg::OFF_DRIVE) |=>
      pin_drive_strength_control_reg ==
      ($past(bus_in.wdata) & iopd_pkg::DRIVE_WMASK);
  endproperty
  a_drive_mask: assert property (p_drive_mask)
    else $error("reserved drive bits stored");

  property p_dir_mask;
    @(posedge sys_clk_in) disable iff (rst_in)
    s_dir_write |=>
      port_direction_register_reg == ($past(bus_in.wdata) & PIN_PRESENT);
  endproperty
  a_dir_mask: assert property (p_dir_mask)
    else $error("absent pin direction stored");

  property p_buz_force;
    @(posedge sys_clk_in) disable iff (rst_in)
    alt_in.buz_en && PIN_PRESENT[iopd_pkg::BUZZER_PIN] |=>
      pin_oe_out[iopd_pkg::BUZZER_PIN];
  endproperty
  a_buz_force: assert property (p_buz_force)
    else $error("buzzer pin not forced to output");

  // checked while reset is held, so no disable clause here
  property p_reset_state;
    @(posedge sys_clk_in)
    rst_in |=> port_direction_register_reg == iopd_pkg::RESET_BYTE &&
      port_data_latch_reg == iopd_pkg::RESET_BYTE;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset left direction or latch set");

endmodule

// *** testbench.sv ***
// self-checking bench for the port A block
// assumes the board model resolves pin levels fed back to pin_in
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  iopd_pkg::iopd_bus_type bus = '0;
  iopd_pkg::iopd_alt_type alt = '0;
  logic [7:0] board_val = 8'h00, board_en = 8'h00;
  logic [7:0] lvl, rdata, pin_o, pin_oe, pull, per;
  logic ia, ib, hd4, hd5;
  logic rd_pend = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] lf = 8'h23, lat, dir;
  int error_cnt = 0, checked = 0;

  iopd_port uut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .bus_in(bus),
    .rdata_out(rdata), .alt_in(alt), .pin_in(lvl), .pin_out(pin_o),
    .pin_oe_out(pin_oe), .pullup_en_out(pull), .periph_in_out(per),
    .external_interrupt_a_out(ia), .external_interrupt_b_out(ib),
    .high_drive_select_pin4_out(hd4), .high_drive_select_pin5_out(hd5));
  iopd_board_model board (.sys_clk_in(sys_clk_in), .pin_out_in(pin_o),
    .pin_oe_in(pin_oe), .pullup_en_in(pull), .board_val_in(board_val),
    .board_en_in(board_en), .pin_level_out(lvl));

  initial begin
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  task automatic cmp_rd(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_pin(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t pin got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
  endtask
  // read: note the expected byte for the monitor
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_in) bus <= '0;
  endtask
  task automatic test_done;
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ****************************************************************
  // read monitor: data stands only the cycle after the strobe
  // ****************************************************************
  always @(posedge sys_clk_in) rd_pend <= bus.rd;
  always @(negedge sys_clk_in) begin
    if (rd_pend) begin
      cmp_rd(rdata, exp_q.pop_front());
    end
  end
  // watchdog at 5000 cycles, far beyond the roughly 105 cycles needed
  initial begin
    #40000;
    error_cnt++;
    test_done();
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (10) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    idle(2);
    cmp_pin(pin_oe, 8'h00);
    cmp_pin(pull, 8'hff);
    rd(iopd_pkg::OFF_DATA, 8'hff);
    rd(iopd_pkg::OFF_DIR, 8'h00);
    rd(iopd_pkg::OFF_DRIVE, 8'h00);
    rd(4'hf, 8'h00);
    wr(iopd_pkg::OFF_DATA, 8'ha5);
    wr(iopd_pkg::OFF_DIR, 8'h0f);
    board_en <= 8'hff;
    board_val <= 8'h3c;
    idle(3);
    cmp_pin(pin_oe, 8'h0f);
    cmp_pin(pin_o, 8'h05);
    cmp_pin(pull, 8'hf0);
    rd(iopd_pkg::OFF_DIR, 8'h0f);
    rd(iopd_pkg::OFF_DATA, 8'h35);
    // random latch, direction and board levels
    for (int i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      lat = lf;
      lf = lfsr(lf);
      dir = lf;
      lf = lfsr(lf);
      wr(iopd_pkg::OFF_DATA, lat);
      wr(iopd_pkg::OFF_DIR, dir);
      rd(iopd_pkg::OFF_DIR, dir);
      board_val <= lf;
      idle(3);
      rd(iopd_pkg::OFF_DATA, (lat & dir) | (lf & ~dir));
    end
    // pwm outputs take pins 0 to 5 whatever the direction
    wr(iopd_pkg::OFF_DIR, 8'h00);
    board_val <= 8'h00;
    alt <= '{pwm_out: 6'h2a, pwm_oe: 6'h3f, buz_out: 1'b0, buz_en: 1'b0};
    idle(3);
    cmp_pin(pin_oe, 8'h3f);
    cmp_pin(pin_o, 8'h2a);
    rd(iopd_pkg::OFF_DATA, 8'h2a);
    rd(iopd_pkg::OFF_STATUS, 8'h3f);
    // alternate pins still read the pin with the direction bit set
    wr(iopd_pkg::OFF_DATA, 8'h15);
    wr(iopd_pkg::OFF_DIR, 8'h3f);
    idle(3);
    rd(iopd_pkg::OFF_DATA, 8'h2a);
    wr(iopd_pkg::OFF_DIR, 8'h00);
    wr(iopd_pkg::OFF_DRIVE, 8'hfe);
    alt.buz_en <= 1'b1;
    idle(3);
    cmp_pin(pin_o, 8'h0a);
    cmp_pin({7'h00, hd5}, 8'h01);
    cmp_pin({7'h00, hd4}, 8'h01);
    rd(iopd_pkg::OFF_DRIVE, 8'h06);
    alt <= '0;
    idle(3);
    cmp_pin({6'h00, hd5, hd4}, 8'h00);
    // interrupt lines and peripheral inputs follow the pins
    board_val <= 8'h80;
    idle(4);
    cmp_pin({6'h00, ib, ia}, 8'h02);
    cmp_pin(per, 8'h80);
    test_done();
  end
endmodule
